//--- ifsr_evsrc.sv
// Event source model for the serial port and converter pair requests.
`timescale 1ns/1ns
module ifsr_evsrc (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [5:0] ev_cmd,
   output logic serial_error_req,
   output logic [4:0] conv_done_req
);
   // A command bit is registered and drives its request from the next cycle, for as long as it is held.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_error_req <= 1'b0;
         conv_done_req <= 5'h00;
      end else begin
         serial_error_req <= ev_cmd[5];
         conv_done_req <= ev_cmd[4:0];
      end
   end
endmodule : ifsr_evsrc

//--- ifsr_flag.sv
// One sticky event flag with software write and set-over-clear priority.
`timescale 1ns/1ns
module ifsr_flag
   import ifsr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic event_in,
   input wire logic wr_en,
   input wire logic wr_val,
   output logic flag
);
   logic flag_r;

   // An event in the same cycle as a software write of 0 keeps the flag set.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_r <= IFSR_FLAG_RST[0];
      end else if (ce) begin
         if (event_in) begin
            flag_r <= 1'b1;
         end else if (wr_en) begin
            flag_r <= wr_val;
         end
      end
   end

   assign flag = flag_r;

   property p_set_holds;
      @(posedge pclk) disable iff (!presetn)
      (ce && event_in) |=> flag;
   endproperty
   a_set_holds: assert property (p_set_holds)
      else $error("Flag not set after event.");

   property p_sticky;
      @(posedge pclk) disable iff (!presetn)
      (flag && !(ce && wr_en && !wr_val)) |=> flag;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("Flag dropped without a clearing write.");
endmodule : ifsr_flag

//--- ifsr_pkg.sv
// Package with register map, field layout and bus carriers for the flag block.
package ifsr_pkg;
   localparam int unsigned IFSR_AW = 8;
   localparam logic [7:0] IFSR_OFF_SERR = 8'h00;
   localparam logic [7:0] IFSR_OFF_CONV = 8'h04;
   localparam logic [7:0] IFSR_OFF_STAT = 8'h08;
   localparam logic [7:0] IFSR_OFF_MASK = 8'h0C;
   localparam int unsigned IFSR_SERR_BIT = 1;
   localparam int unsigned IFSR_CONV_LSB = 0;
   localparam int unsigned IFSR_NCONV = 5;
   localparam int unsigned IFSR_NEV = 6;
   localparam logic [15:0] IFSR_SERR_MASK = 16'h0002;
   localparam logic [15:0] IFSR_CONV_MASK = 16'h001F;
   localparam logic [15:0] IFSR_FLAG_RST = 16'h0000;
   localparam logic [5:0] IFSR_IRQ_RST = 6'h00;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [IFSR_AW-1:0] paddr;
      logic [31:0] pwdata;
   } ifsr_apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } ifsr_apb_rsp_t;
endpackage : ifsr_pkg

//--- ifsr_regs.sv
// APB register block holding the serial-error and conversion-done flags.
`timescale 1ns/1ns
module ifsr_regs
   import ifsr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [IFSR_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_error_req,
   input wire logic [IFSR_NCONV-1:0] conv_done_req,
   output logic [15:0] serial_error_flag_status,
   output logic [15:0] converter_done_flag_status,
   output logic irq
);
   ifsr_apb_req_t req;
   ifsr_apb_rsp_t rsp;
   logic [IFSR_NEV-1:0] ev;
   logic [IFSR_NEV-1:0] flags;
   logic [IFSR_NEV-1:0] wr_en;
   logic [IFSR_NEV-1:0] wr_val;
   logic [IFSR_NEV-1:0] stat_r;
   logic [IFSR_NEV-1:0] mask_r;
   logic [31:0] prdata_r;
   logic [31:0] rd_nxt;
   logic wr_acc;
   logic rd_acc;

   function automatic logic hit(input logic [IFSR_AW-1:0] a,
                                input logic [7:0] off);
      return a == off;
   endfunction : hit

   function automatic logic mapped(input logic [IFSR_AW-1:0] a);
      return hit(a, IFSR_OFF_SERR) || hit(a, IFSR_OFF_CONV) ||
             hit(a, IFSR_OFF_STAT) || hit(a, IFSR_OFF_MASK);
   endfunction : mapped

   assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                  paddr: paddr, pwdata: pwdata};
   assign wr_acc = ce && req.psel && req.penable && req.pwrite;
   assign rd_acc = ce && req.psel && !req.penable && !req.pwrite;
   assign ev = {serial_error_req, conv_done_req};

   // Index 5 is the serial error flag, 4..0 are pairs 6..2.
   genvar i;
   generate
      for (i = 0; i < IFSR_NEV; i++) begin : g_flag
         if (i == IFSR_NEV - 1) begin : g_serr
            assign wr_en[i] = wr_acc && hit(req.paddr, IFSR_OFF_SERR);
            assign wr_val[i] = req.pwdata[IFSR_SERR_BIT];
         end else begin : g_conv
            assign wr_en[i] = wr_acc && hit(req.paddr, IFSR_OFF_CONV);
            assign wr_val[i] = req.pwdata[IFSR_CONV_LSB + i];
         end
         ifsr_flag ifsr_flag_inst (
            .pclk(pclk),
            .presetn(presetn),
            .ce(ce),
            .event_in(ev[i]),
            .wr_en(wr_en[i]),
            .wr_val(wr_val[i]),
            .flag(flags[i])
         );
      end
   endgenerate

   // Unimplemented bits are tied low.
   always_comb begin
      serial_error_flag_status = 16'h0000;
      serial_error_flag_status[IFSR_SERR_BIT] = flags[IFSR_NEV-1];
      converter_done_flag_status = 16'h0000;
      converter_done_flag_status[IFSR_CONV_LSB +: IFSR_NCONV] =
         flags[IFSR_NCONV-1:0];
   end

   // Interrupt status: sticky on event, write one to clear, set wins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_r <= IFSR_IRQ_RST;
      end else if (ce) begin
         if (wr_acc && hit(req.paddr, IFSR_OFF_STAT)) begin
            stat_r <= (stat_r & ~req.pwdata[IFSR_NEV-1:0]) | ev;
         end else begin
            stat_r <= stat_r | ev;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_r <= IFSR_IRQ_RST;
      end else if (wr_acc && hit(req.paddr, IFSR_OFF_MASK)) begin
         mask_r <= req.pwdata[IFSR_NEV-1:0];
      end
   end

   assign irq = |(stat_r & mask_r);

   always_comb begin
      rd_nxt = 32'h00000000;
      if (hit(req.paddr, IFSR_OFF_SERR)) begin
         rd_nxt[15:0] = serial_error_flag_status;
      end else if (hit(req.paddr, IFSR_OFF_CONV)) begin
         rd_nxt[15:0] = converter_done_flag_status;
      end else if (hit(req.paddr, IFSR_OFF_STAT)) begin
         rd_nxt[IFSR_NEV-1:0] = stat_r;
      end else if (hit(req.paddr, IFSR_OFF_MASK)) begin
         rd_nxt[IFSR_NEV-1:0] = mask_r;
      end
   end

   // Read data is captured in the setup cycle and held through access.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h00000000;
      end else if (rd_acc) begin
         prdata_r <= rd_nxt;
      end
   end

   assign rsp.pready = ce;
   assign rsp.pslverr = req.psel && req.penable && !mapped(req.paddr);
   assign rsp.prdata = prdata_r;
   assign pready = rsp.pready;
   assign pslverr = rsp.pslverr;
   assign prdata = rsp.prdata;

   property p_serr_zero;
      @(posedge pclk) disable iff (!presetn)
      (serial_error_flag_status & ~IFSR_SERR_MASK) == 16'h0000;
   endproperty
   a_serr_zero: assert property (p_serr_zero)
      else $error("Serial register unimplemented bit set.");

   property p_serr_wr;
      @(posedge pclk) disable iff (!presetn)
      (wr_acc && hit(req.paddr, IFSR_OFF_SERR) && !serial_error_req)
         |=> serial_error_flag_status[IFSR_SERR_BIT] ==
             $past(req.pwdata[IFSR_SERR_BIT]);
   endproperty
   a_serr_wr: assert property (p_serr_wr)
      else $error("Serial flag write not stored.");

   property p_serr_set;
      @(posedge pclk) disable iff (!presetn)
      (ce && serial_error_req) |=> serial_error_flag_status[IFSR_SERR_BIT];
   endproperty
   a_serr_set: assert property (p_serr_set)
      else $error("Serial flag not set by request.");

   property p_conv_set;
      @(posedge pclk) disable iff (!presetn)
      ce |=> ((converter_done_flag_status[IFSR_NCONV-1:0] &
               $past(conv_done_req)) == $past(conv_done_req));
   endproperty
   a_conv_set: assert property (p_conv_set)
      else $error("Conversion flag not set by request.");

   property p_conv_zero;
      @(posedge pclk) disable iff (!presetn)
      (converter_done_flag_status & ~IFSR_CONV_MASK) == 16'h0000;
   endproperty
   a_conv_zero: assert property (p_conv_zero)
      else $error("Converter register unimplemented bit set.");

   property p_conv_clr;
      @(posedge pclk) disable iff (!presetn)
      (wr_acc && hit(req.paddr, IFSR_OFF_CONV) && conv_done_req == 5'h00 &&
       req.pwdata[4:0] == 5'h00)
         |=> converter_done_flag_status == 16'h0000;
   endproperty
   a_conv_clr: assert property (p_conv_clr)
      else $error("Conversion flags not cleared by write of zero.");

   property p_rd_zero_high;
      @(posedge pclk) disable iff (!presetn)
      (rd_acc && (hit(req.paddr, IFSR_OFF_SERR) ||
                  hit(req.paddr, IFSR_OFF_CONV)))
         |=> prdata[31:16] == 16'h0000 && prdata[15:5] == 11'h000;
   endproperty
   a_rd_zero_high: assert property (p_rd_zero_high)
      else $error("Read returned unimplemented bits.");

   property p_irq;
      @(posedge pclk) disable iff (!presetn)
      (ce && serial_error_req && mask_r[IFSR_NEV-1]) |=> irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("Interrupt not raised for unmasked serial error.");

   // A low clock enable must freeze every flag, status, mask and read word.
   property p_freeze;
      @(posedge pclk) disable iff (!presetn)
      !ce |=> $stable(flags) && $stable(stat_r) && $stable(mask_r) &&
              $stable(prdata_r);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("State changed while the clock enable was low.");

   property p_unmapped_wr;
      @(posedge pclk) disable iff (!presetn)
      (wr_acc && !mapped(req.paddr) && ev == 6'h00)
         |=> $stable(flags) && $stable(stat_r) && $stable(mask_r);
   endproperty
   a_unmapped_wr: assert property (p_unmapped_wr)
      else $error("Write to an unmapped address changed state.");

   property p_stat_set;
      @(posedge pclk) disable iff (!presetn)
      ce |=> ((stat_r & $past(ev)) == $past(ev));
   endproperty
   a_stat_set: assert property (p_stat_set)
      else $error("Interrupt status bit not set by its event.");

   property p_stat_w1c;
      @(posedge pclk) disable iff (!presetn)
      (wr_acc && hit(req.paddr, IFSR_OFF_STAT) && ev == 6'h00)
         |=> stat_r == ($past(stat_r) & ~$past(req.pwdata[IFSR_NEV-1:0]));
   endproperty
   a_stat_w1c: assert property (p_stat_w1c)
      else $error("Interrupt status not cleared by writing one.");

   property p_mask_wr;
      @(posedge pclk) disable iff (!presetn)
      (wr_acc && hit(req.paddr, IFSR_OFF_MASK))
         |=> mask_r == $past(req.pwdata[IFSR_NEV-1:0]);
   endproperty
   a_mask_wr: assert property (p_mask_wr)
      else $error("Mask write not stored.");

   property p_mask_hold;
      @(posedge pclk) disable iff (!presetn)
      !(wr_acc && hit(req.paddr, IFSR_OFF_MASK)) |=> $stable(mask_r);
   endproperty
   a_mask_hold: assert property (p_mask_hold)
      else $error("Mask changed without a mask write.");

   property p_irq_conv;
      @(posedge pclk) disable iff (!presetn)
      (ce && (conv_done_req & mask_r[IFSR_NCONV-1:0]) != 5'h00 &&
       !(wr_acc && hit(req.paddr, IFSR_OFF_MASK))) |=> irq;
   endproperty
   a_irq_conv: assert property (p_irq_conv)
      else $error("Interrupt not raised for unmasked conversion event.");

   property p_rd_serr;
      @(posedge pclk) disable iff (!presetn)
      (rd_acc && hit(req.paddr, IFSR_OFF_SERR))
         |=> prdata == {16'h0000, $past(serial_error_flag_status)};
   endproperty
   a_rd_serr: assert property (p_rd_serr)
      else $error("Serial register read returned a wrong word.");

   property p_rd_conv;
      @(posedge pclk) disable iff (!presetn)
      (rd_acc && hit(req.paddr, IFSR_OFF_CONV))
         |=> prdata == {16'h0000, $past(converter_done_flag_status)};
   endproperty
   a_rd_conv: assert property (p_rd_conv)
      else $error("Converter register read returned a wrong word.");

   property p_rd_unmapped;
      @(posedge pclk) disable iff (!presetn)
      (rd_acc && !mapped(req.paddr)) |=> prdata == 32'h00000000;
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped)
      else $error("Unmapped read returned a nonzero word.");

   property p_conv_wr;
      @(posedge pclk) disable iff (!presetn)
      (wr_acc && hit(req.paddr, IFSR_OFF_CONV) && conv_done_req == 5'h00)
         |=> converter_done_flag_status[IFSR_NCONV-1:0] ==
             $past(req.pwdata[IFSR_NCONV-1:0]);
   endproperty
   a_conv_wr: assert property (p_conv_wr)
      else $error("Conversion flag write not stored.");

   property p_serr_hold;
      @(posedge pclk) disable iff (!presetn)
      (!serial_error_req && !(wr_acc && hit(req.paddr, IFSR_OFF_SERR)))
         |=> $stable(serial_error_flag_status);
   endproperty
   a_serr_hold: assert property (p_serr_hold)
      else $error("Serial flag changed without request or write.");

   property p_conv_hold;
      @(posedge pclk) disable iff (!presetn)
      (conv_done_req == 5'h00 && !(wr_acc && hit(req.paddr, IFSR_OFF_CONV)))
         |=> $stable(converter_done_flag_status);
   endproperty
   a_conv_hold: assert property (p_conv_hold)
      else $error("Conversion flags changed without request or write.");
endmodule : ifsr_regs

//--- irq_flag_status_regs_tb.sv
// Self-checking testbench for the flag register block.
`timescale 1ns/1ns
module irq_flag_status_regs_tb
   import ifsr_pkg::*;
;
   logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq, e;
   logic [IFSR_AW-1:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] s_stat, c_stat;
   logic serial_error_req;
   logic [4:0] conv_done_req;
   logic [5:0] ev_cmd;
   int failures, check_count;
   ifsr_regs ifsr_regs_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serial_error_req(serial_error_req),
      .conv_done_req(conv_done_req), .serial_error_flag_status(s_stat),
      .converter_done_flag_status(c_stat), .irq(irq));
   ifsr_evsrc ifsr_evsrc_inst (.pclk(pclk), .presetn(presetn),
      .ev_cmd(ev_cmd), .serial_error_req(serial_error_req),
      .conv_done_req(conv_done_req));
   task chk(input logic [31:0] g, input logic [31:0] x);
      check_count++;
      if (g !== x) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, g, x);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(q, x);
   endtask : rd
   task fire(input logic [5:0] v);
      ev_cmd <= v;
      @(posedge pclk);
      ev_cmd <= 6'h00;
      repeat (3) @(posedge pclk);
   endtask : fire
   task t_reset;
      rd(IFSR_OFF_SERR, 32'h0);
      rd(IFSR_OFF_CONV, 32'h0);
   endtask : t_reset
   task t_bits;
      apb(1'b1, IFSR_OFF_SERR, 32'hFFFFFFFF);
      rd(IFSR_OFF_SERR, 32'h2);
      chk({16'h0, s_stat}, 32'h2);
      apb(1'b1, IFSR_OFF_SERR, 32'hFFFFFFFD);
      rd(IFSR_OFF_SERR, 32'h0);
      apb(1'b1, IFSR_OFF_CONV, 32'hFFFFFFFF);
      rd(IFSR_OFF_CONV, 32'h1F);
      apb(1'b1, IFSR_OFF_CONV, 32'hFFFFFFE0);
      rd(IFSR_OFF_CONV, 32'h0);
   endtask : t_bits
   task t_events;
      for (int i = 0; i < 6; i++) begin
         fire(6'h01 << i);
         if (i == 5) begin
            rd(IFSR_OFF_SERR, 32'h2);
            apb(1'b1, IFSR_OFF_SERR, 32'h0);
            rd(IFSR_OFF_SERR, 32'h0);
         end else begin
            rd(IFSR_OFF_CONV, 32'h1 << i);
            chk({16'h0, c_stat}, 32'h1 << i);
            apb(1'b1, IFSR_OFF_CONV, 32'h0);
            rd(IFSR_OFF_CONV, 32'h0);
         end
      end
      apb(1'b1, IFSR_OFF_STAT, 32'h3F);
   endtask : t_events
   task t_irq;
      fire(6'h21);
      rd(IFSR_OFF_STAT, 32'h21);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, IFSR_OFF_MASK, 32'h20);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, IFSR_OFF_STAT, 32'h20);
      rd(IFSR_OFF_STAT, 32'h01);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, IFSR_OFF_MASK, 32'h01);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, IFSR_OFF_STAT, 32'h01);
      chk({31'h0, irq}, 32'h0);
      rd(IFSR_OFF_SERR, 32'h2);
      apb(1'b1, IFSR_OFF_MASK, 32'h21);
      fire(6'h21);
      chk({31'h0, irq}, 32'h1);
      rd(IFSR_OFF_STAT, 32'h21);
      apb(1'b1, IFSR_OFF_STAT, 32'h21);
      chk({31'h0, irq}, 32'h0);
   endtask : t_irq
   task t_unmapped;
      apb(1'b1, 8'h10, 32'hFFFFFFFF);
      chk({31'h0, e}, 32'h1);
      rd(8'h10, 32'h0);
      rd(IFSR_OFF_CONV, 32'h1);
   endtask : t_unmapped
   task t_midreset;
      fire(6'h3F);
      chk({31'h0, irq}, 32'h1);
      presetn <= 1'b0;
      @(posedge pclk);
      chk({16'h0, s_stat}, 32'h0);
      chk({16'h0, c_stat}, 32'h0);
      chk({31'h0, irq}, 32'h0);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(IFSR_OFF_STAT, 32'h0);
      rd(IFSR_OFF_MASK, 32'h0);
   endtask : t_midreset
   task t_freeze;
      ce <= 1'b0;
      fire(6'h3F);
      chk({31'h0, pready}, 32'h0);
      ce <= 1'b1;
      @(posedge pclk);
      rd(IFSR_OFF_CONV, 32'h0);
      rd(IFSR_OFF_SERR, 32'h0);
      rd(IFSR_OFF_STAT, 32'h0);
   endtask : t_freeze
   task close_out;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      #40000;
      failures++;
      close_out();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, ev_cmd} = '0;
      ce = 1'b1;
      failures = 0;
      check_count = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_bits();
      t_events();
      t_irq();
      t_unmapped();
      t_midreset();
      t_freeze();
      close_out();
   end
endmodule : irq_flag_status_regs_tb
